// *** common/sts_pkg.sv ***
package sts_pkg;

  // Command codes
  localparam logic [7:0] CMD_LIMIT = 8'h62;
  localparam logic [7:0] CMD_ACTION = 8'h63;
  localparam logic [7:0] CMD_TOFF = 8'h64;

  // Linear word layout: mantissa bits below, fixed-zero bits above
  localparam int MANT_W = 7;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [15:0] TOFF_RST = 16'h0000;

  // Action register fields
  localparam int ACT_SEL_BIT = 7;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;
  localparam logic [7:0] ACT_RST = 8'hBF;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STUCK_WAIT_S = 4;
  localparam int MS_W = 13;
  localparam logic [MS_W-1:0] STUCK_WAIT_MS = MS_W'(STUCK_WAIT_S * 1000);
  localparam logic [MS_W-1:0] RETRY_RAMPS = MS_W'(7);

  // Bucket table: upper bound of each bucket and its effective time
  localparam int NBKT = 15;
  localparam logic [MANT_W-1:0] BKT_HI [NBKT] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h09,
    7'h0C, 7'h11, 7'h16, 7'h20, 7'h2C, 7'h3E, 7'h56};
  localparam logic [MANT_W-1:0] BKT_MS [NBKT] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
    7'h0A, 7'h0E, 7'h13, 7'h1B, 7'h25, 7'h34, 7'h48};
  localparam logic [MANT_W-1:0] BKT_TOP_MS = 7'h64;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RAMP = 3'b001,
    ST_ON = 3'b010,
    ST_LATCH = 3'b011,
    ST_RETRY = 3'b100,
    ST_TOFF = 3'b101
  } sts_state_e;

  // Smallest bucket whose upper bound holds the value wins
  function automatic logic [MANT_W-1:0] sts_bucket(input logic [MANT_W-1:0] mant);
    logic [MANT_W-1:0] ms;
    logic hit;
    ms = BKT_TOP_MS;
    hit = 1'b0;
    for (int i = 0; i < NBKT; i++)
    begin
      if (!hit && mant <= BKT_HI[i])
      begin
        ms = BKT_MS[i];
        hit = 1'b1;
      end
    end
    return ms;
  endfunction

endpackage

// *** common/sts_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface sts_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

`default_nettype wire

// *** src/sts_ms_tick.sv ***
`timescale 1ns/1ps
`default_nettype none

module sts_ms_tick #(
  parameter int TICK_CYCLES = sts_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Millisecond timebase
  sts_tick_if.src tb
);

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] div_r;
  logic tick_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      div_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == LAST);
      div_r <= (div_r == LAST) ? '0 : div_r + CW'(1);
    end
  end

  assign tb.tick = tick_r;

endmodule // sts_ms_tick

`default_nettype wire

// *** src/sts_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module sts_sequencer #(
  parameter int TICK_CYCLES = sts_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Decoded command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid_r,
  output logic rsp_nack_r,
  output logic [15:0] rsp_rdata_r,
  // Device control
  input wire logic loop_secondary,
  input wire logic clear_faults,
  input wire logic alert_mask,
  input wire logic on_cmd,
  input wire logic vout_above_uv,
  input wire logic [6:0] ramp_ms,
  // Nonvolatile storage
  input wire logic store_default_all,
  input wire logic restore_default_all,
  input wire logic nv_sel_in,
  input wire logic nv_retry_in,
  input wire logic [6:0] nv_toff_in,
  output logic nv_store_r,
  output logic nv_sel_r,
  output logic nv_retry_r,
  output logic [6:0] nv_toff_r,
  // Power stage
  output logic soft_start_r,
  output logic out_en_r,
  output logic ramp_down_r,
  // Status
  output logic status_other_r,
  output logic status_vout_warn_r,
  output logic status_tonmax_r,
  output logic status_comm_r,
  output logic cml_invalid_data_r,
  output logic invalid_command_fault_r,
  output logic smbalert_r
);

  localparam int MW = sts_pkg::MANT_W;
  localparam int MS = sts_pkg::MS_W;

  sts_tick_if tb_if ();

  sts_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .tb(tb_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic [MW-1:0] limit_mant_r;
  logic [MW-1:0] toff_mant_r;
  logic act_sel_r;
  logic act_retry_r;
  logic ours;
  logic refuse_sec;
  logic wr_ok;
  logic act_wr;
  logic bad_retry;
  logic [2:0] wr_retry;

  assign ours = (cmd_code == sts_pkg::CMD_LIMIT) || (cmd_code == sts_pkg::CMD_ACTION) ||
                (cmd_code == sts_pkg::CMD_TOFF);
  assign refuse_sec = cmd_valid && ours && loop_secondary;
  assign wr_ok = cmd_valid && cmd_write && !loop_secondary;
  assign act_wr = wr_ok && (cmd_code == sts_pkg::CMD_ACTION);
  assign wr_retry = cmd_wdata[sts_pkg::ACT_RETRY_HI:sts_pkg::ACT_RETRY_LO];
  assign bad_retry = act_wr && (wr_retry != sts_pkg::RETRY_NONE) &&
                     (wr_retry != sts_pkg::RETRY_ALWAYS);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      limit_mant_r <= sts_pkg::LIMIT_RST[MW-1:0];
      toff_mant_r <= sts_pkg::TOFF_RST[MW-1:0];
      act_sel_r <= sts_pkg::ACT_RST[sts_pkg::ACT_SEL_BIT];
      act_retry_r <= sts_pkg::ACT_RST[sts_pkg::ACT_RETRY_HI];
    end
    else if (restore_default_all)
    begin
      limit_mant_r <= sts_pkg::LIMIT_RST[MW-1:0];
      toff_mant_r <= nv_toff_in;
      act_sel_r <= nv_sel_in;
      act_retry_r <= nv_retry_in;
    end
    else
    begin
      if (wr_ok && cmd_code == sts_pkg::CMD_LIMIT)
        limit_mant_r <= cmd_wdata[MW-1:0];
      if (wr_ok && cmd_code == sts_pkg::CMD_TOFF)
        toff_mant_r <= cmd_wdata[MW-1:0];
      if (act_wr && !bad_retry)
      begin
        act_sel_r <= cmd_wdata[sts_pkg::ACT_SEL_BIT];
        act_retry_r <= cmd_wdata[sts_pkg::ACT_RETRY_HI];
      end
    end
  end

  // Upper bits are wired to zero, so no write can reach them
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    case (cmd_code)
      sts_pkg::CMD_LIMIT: rd_mux[MW-1:0] = limit_mant_r;
      sts_pkg::CMD_TOFF: rd_mux[MW-1:0] = toff_mant_r;
      sts_pkg::CMD_ACTION:
      begin
        rd_mux[sts_pkg::ACT_SEL_BIT] = act_sel_r;
        rd_mux[sts_pkg::ACT_RETRY_HI:sts_pkg::ACT_RETRY_LO] = {3{act_retry_r}};
        rd_mux[sts_pkg::ACT_DELAY_HI:sts_pkg::ACT_DELAY_LO] = {3{act_retry_r}};
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rsp_valid_r <= 1'b0;
      rsp_nack_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
    end
    else
    begin
      rsp_valid_r <= cmd_valid;
      rsp_nack_r <= cmd_valid && (!ours || loop_secondary || bad_retry);
      rsp_rdata_r <= (cmd_valid && ours && !loop_secondary && !cmd_write) ? rd_mux : 16'h0000;
    end
  end

  // Nonvolatile image: select bit, a single retry bit and the off-time mantissa
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      nv_store_r <= 1'b0;
      nv_sel_r <= 1'b0;
      nv_retry_r <= 1'b0;
      nv_toff_r <= 7'h00;
    end
    else
    begin
      nv_store_r <= store_default_all;
      if (store_default_all)
      begin
        nv_sel_r <= act_sel_r;
        nv_retry_r <= act_retry_r;
        nv_toff_r <= toff_mant_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  sts_pkg::sts_state_e state_r;
  sts_pkg::sts_state_e state_nxt;
  logic [MS-1:0] ms_cnt_r;
  logic [MW-1:0] limit_ms;
  logic [MW-1:0] toff_ms;
  logic [MS-1:0] deadline;
  logic timeout;

  assign limit_ms = sts_pkg::sts_bucket(limit_mant_r);
  assign toff_ms = sts_pkg::sts_bucket(toff_mant_r);
  // Limit below the ramp time falls back to the long stuck-ramp wait
  assign deadline = (limit_ms >= ramp_ms) ? MS'(limit_ms) :
                    MS'(ramp_ms) + sts_pkg::STUCK_WAIT_MS;
  assign timeout = (state_r == sts_pkg::ST_RAMP) && on_cmd && !vout_above_uv &&
                   (limit_mant_r != '0) && (ms_cnt_r > deadline);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      sts_pkg::ST_OFF:
        if (on_cmd)
          state_nxt = sts_pkg::ST_RAMP;
      sts_pkg::ST_RAMP:
        if (!on_cmd)
          state_nxt = sts_pkg::ST_TOFF;
        else if (vout_above_uv)
          state_nxt = sts_pkg::ST_ON;
        else if (timeout)
          state_nxt = !act_sel_r ? sts_pkg::ST_ON :
                      (act_retry_r ? sts_pkg::ST_RETRY : sts_pkg::ST_LATCH);
      sts_pkg::ST_ON:
        if (!on_cmd)
          state_nxt = sts_pkg::ST_TOFF;
      sts_pkg::ST_LATCH:
        if (clear_faults)
          state_nxt = sts_pkg::ST_OFF;
      sts_pkg::ST_RETRY:
        if (!on_cmd)
          state_nxt = sts_pkg::ST_OFF;
        else if (ms_cnt_r > MS'(ramp_ms) * sts_pkg::RETRY_RAMPS)
          state_nxt = sts_pkg::ST_RAMP;
      sts_pkg::ST_TOFF:
        if (ms_cnt_r > MS'(toff_ms))
          state_nxt = sts_pkg::ST_OFF;
      default: state_nxt = sts_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_r <= sts_pkg::ST_OFF;
    else
      state_r <= state_nxt;
  end

  // Restarts on state change; first tick is partial, so compares are strict and no wait ends early
  always_ff @(posedge clk_sys)
  begin
    if (rst || state_nxt != state_r)
      ms_cnt_r <= '0;
    else if (tb_if.tick && ms_cnt_r != '1)
      ms_cnt_r <= ms_cnt_r + MS'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      soft_start_r <= 1'b0;
      out_en_r <= 1'b0;
      ramp_down_r <= 1'b0;
    end
    else
    begin
      soft_start_r <= (state_nxt == sts_pkg::ST_RAMP);
      out_en_r <= (state_nxt == sts_pkg::ST_RAMP) || (state_nxt == sts_pkg::ST_ON) ||
                  (state_nxt == sts_pkg::ST_TOFF);
      ramp_down_r <= (state_r == sts_pkg::ST_TOFF) && (state_nxt == sts_pkg::ST_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over clear

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      status_other_r <= 1'b0;
      status_vout_warn_r <= 1'b0;
      status_tonmax_r <= 1'b0;
      status_comm_r <= 1'b0;
      cml_invalid_data_r <= 1'b0;
      invalid_command_fault_r <= 1'b0;
      smbalert_r <= 1'b0;
    end
    else
    begin
      status_other_r <= timeout || (status_other_r && !clear_faults);
      status_vout_warn_r <= timeout || (status_vout_warn_r && !clear_faults);
      status_tonmax_r <= timeout || (status_tonmax_r && !clear_faults);
      status_comm_r <= bad_retry || refuse_sec || (status_comm_r && !clear_faults);
      cml_invalid_data_r <= bad_retry || (cml_invalid_data_r && !clear_faults);
      invalid_command_fault_r <= refuse_sec || (invalid_command_fault_r && !clear_faults);
      smbalert_r <= (!alert_mask && (timeout || bad_retry || refuse_sec)) ||
                    (smbalert_r && !clear_faults);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_limit_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_valid && !cmd_write && cmd_code == sts_pkg::CMD_LIMIT) |=> (rsp_rdata_r[15:MW] == '0))
    else $error("limit upper bits not zero");

  a_delay_mirror: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_valid && !cmd_write && !loop_secondary && cmd_code == sts_pkg::CMD_ACTION)
    |=> (rsp_rdata_r[2:0] == {3{rsp_rdata_r[5]}}) && (rsp_rdata_r[5:3] == {3{rsp_rdata_r[5]}}))
    else $error("delay field not a copy of retry bit");

  a_bad_retry_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (bad_retry && !clear_faults && !restore_default_all) |=> rsp_nack_r && status_comm_r && cml_invalid_data_r &&
    $stable(act_retry_r))
    else $error("bad retry value not rejected");

  a_secondary_refuse: assert property (@(posedge clk_sys) disable iff (rst)
    (refuse_sec && !clear_faults && !restore_default_all) |=> rsp_nack_r &&
    invalid_command_fault_r && $stable(limit_mant_r) && $stable(toff_mant_r))
    else $error("secondary access not refused");

  a_restore_limit: assert property (@(posedge clk_sys) disable iff (rst)
    restore_default_all |=> (limit_mant_r == '0) && !timeout)
    else $error("restore did not clear limit");

  a_timeout_status: assert property (@(posedge clk_sys) disable iff (rst)
    (timeout && !clear_faults) |=> status_other_r && status_vout_warn_r && status_tonmax_r &&
    (smbalert_r || $past(alert_mask)))
    else $error("timeout status missing");

  a_ignore_runs: assert property (@(posedge clk_sys) disable iff (rst)
    (timeout && !act_sel_r) |=> (state_r == sts_pkg::ST_ON) ##1 out_en_r)
    else $error("ignore mode stopped output");

  a_latch_off: assert property (@(posedge clk_sys) disable iff (rst)
    (timeout && act_sel_r && !act_retry_r) |=> (state_r == sts_pkg::ST_LATCH) ##1 !out_en_r)
    else $error("latch-off not entered");

  a_store_image: assert property (@(posedge clk_sys) disable iff (rst)
    store_default_all |=> nv_store_r && (nv_retry_r == $past(act_retry_r)) &&
    (nv_sel_r == $past(act_sel_r)))
    else $error("stored image wrong");

endmodule // sts_sequencer

`default_nettype wire

// *** sim/sts_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sts_host_model (
  // Clock
  input wire logic clk_sys,
  // Command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid_r,
  input wire logic rsp_nack_r,
  input wire logic [15:0] rsp_rdata_r
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Held across the taking edge; answer is registered, so it is stable at the next fall
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] d,
                        output logic ok, output logic nack, output logic [15:0] rd);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = d;
    @(negedge clk_sys);
    ok = rsp_valid_r;
    nack = rsp_nack_r;
    rd = rsp_rdata_r;
    cmd_valid = 1'b0;
    // Idle fields keep moving so no stale value passes for a live one
    cmd_code = ~code;
    cmd_wdata = ~d;
  endtask
endmodule // sts_host_model

`default_nettype wire

// *** sim/tb_sts_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_sts_sequencer;
  localparam int TICKS = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_write, rsp_valid_r, rsp_nack_r;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata_r;
  logic loop_secondary = 1'b0, clear_faults = 1'b0, alert_mask = 1'b0, on_cmd = 1'b0;
  logic vout_above_uv = 1'b0, store_default_all = 1'b0, restore_default_all = 1'b0;
  logic nv_sel_in = 1'b1, nv_retry_in = 1'b0;
  logic [6:0] ramp_ms = 7'h01, nv_toff_in = 7'h05;
  logic nv_store_r, nv_sel_r, nv_retry_r, soft_start_r, out_en_r, ramp_down_r;
  logic status_other_r, status_vout_warn_r, status_tonmax_r, status_comm_r;
  logic cml_invalid_data_r, invalid_command_fault_r, smbalert_r;
  logic [6:0] nv_toff_r;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  always #10 clk_sys = ~clk_sys;

  sts_sequencer #(.TICK_CYCLES(TICKS)) sts_sequencer_i (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r), .rsp_nack_r(rsp_nack_r), .rsp_rdata_r(rsp_rdata_r),
    .loop_secondary(loop_secondary), .clear_faults(clear_faults), .alert_mask(alert_mask),
    .on_cmd(on_cmd), .vout_above_uv(vout_above_uv), .ramp_ms(ramp_ms),
    .store_default_all(store_default_all), .restore_default_all(restore_default_all),
    .nv_sel_in(nv_sel_in), .nv_retry_in(nv_retry_in), .nv_toff_in(nv_toff_in), .nv_store_r(nv_store_r),
    .nv_sel_r(nv_sel_r), .nv_retry_r(nv_retry_r), .nv_toff_r(nv_toff_r), .soft_start_r(soft_start_r),
    .out_en_r(out_en_r), .ramp_down_r(ramp_down_r), .status_other_r(status_other_r),
    .status_vout_warn_r(status_vout_warn_r), .status_tonmax_r(status_tonmax_r),
    .status_comm_r(status_comm_r), .cml_invalid_data_r(cml_invalid_data_r),
    .invalid_command_fault_r(invalid_command_fault_r), .smbalert_r(smbalert_r));

  sts_host_model sts_host_model_i (
    .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r), .rsp_nack_r(rsp_nack_r), .rsp_rdata_r(rsp_rdata_r));

  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      $display("Error at %0t: cycle limit %h reached, expected below %h", $time, cyc, 60000);
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] d, input logic nk,
                     input logic [15:0] rd);
    logic ok;
    logic nack;
    logic [15:0] got;
    sts_host_model_i.access(wr, code, d, ok, nack, got);
    chk({15'h0000, ok}, 16'h0001);
    chk({15'h0000, nack}, {15'h0000, nk});
    chk(got, rd);
  endtask

  task automatic clr();
    clear_faults = 1'b1;
    @(negedge clk_sys);
    clear_faults = 1'b0;
  endtask

  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  // Counters restart on each state change, so a wait of N ms lands between N and N+1 ticks
  task automatic in_win(input int n, input int ms);
    chk(16'(n >= ms * TICKS - 1 && n <= (ms + 1) * TICKS + 4), 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    acc(1'b0, sts_pkg::CMD_LIMIT, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, sts_pkg::CMD_ACTION, 16'h0000, 1'b0, 16'h00BF);
    acc(1'b0, sts_pkg::CMD_TOFF, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, 8'h65, 16'h0000, 1'b1, 16'h0000);
    $display("t_reset done");
  endtask

  task automatic t_regs();
    acc(1'b1, sts_pkg::CMD_LIMIT, 16'hFFFF, 1'b0, 16'h0000);
    acc(1'b0, sts_pkg::CMD_LIMIT, 16'h0000, 1'b0, 16'h007F);
    acc(1'b1, sts_pkg::CMD_TOFF, 16'hFFFF, 1'b0, 16'h0000);
    acc(1'b0, sts_pkg::CMD_TOFF, 16'h0000, 1'b0, 16'h007F);
    for (int v = 1; v < 7; v++)
      acc(1'b1, sts_pkg::CMD_ACTION, 16'(v << 3), 1'b1, 16'h0000);
    chk({12'h000, invalid_command_fault_r, status_comm_r, cml_invalid_data_r, smbalert_r}, 16'h0007);
    acc(1'b0, sts_pkg::CMD_ACTION, 16'h0000, 1'b0, 16'h00BF);
    acc(1'b1, sts_pkg::CMD_ACTION, 16'h0038, 1'b0, 16'h0000);
    acc(1'b0, sts_pkg::CMD_ACTION, 16'h0000, 1'b0, 16'h003F);
    clr();
    restore_default_all = 1'b1;
    @(negedge clk_sys);
    restore_default_all = 1'b0;
    acc(1'b0, sts_pkg::CMD_LIMIT, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, sts_pkg::CMD_ACTION, 16'h0000, 1'b0, 16'h0080);
    acc(1'b0, sts_pkg::CMD_TOFF, 16'h0000, 1'b0, 16'h0005);
    acc(1'b1, sts_pkg::CMD_TOFF, 16'h0012, 1'b0, 16'h0000);
    acc(1'b1, sts_pkg::CMD_ACTION, 16'h0038, 1'b0, 16'h0000);
    store_default_all = 1'b1;
    @(negedge clk_sys);
    store_default_all = 1'b0;
    chk({6'h00, nv_store_r, nv_sel_r, nv_retry_r, nv_toff_r}, 16'h0292);
    $display("t_regs done");
  endtask

  task automatic t_secondary();
    loop_secondary = 1'b1;
    acc(1'b1, sts_pkg::CMD_LIMIT, 16'h0005, 1'b1, 16'h0000);
    acc(1'b0, sts_pkg::CMD_ACTION, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, sts_pkg::CMD_TOFF, 16'h0000, 1'b1, 16'h0000);
    chk({12'h000, invalid_command_fault_r, status_comm_r, cml_invalid_data_r, smbalert_r}, 16'h000D);
    loop_secondary = 1'b0;
    acc(1'b0, sts_pkg::CMD_LIMIT, 16'h0000, 1'b0, 16'h0000);
    clr();
    $display("t_secondary done");
  endtask

  task automatic t_buckets();
    logic [15:0] lim [6] = '{16'h0001, 16'h0009, 16'h000A, 16'h0056, 16'h0057, 16'h0001};
    int exp_ms [6] = '{1, 7, 10, 72, 100, 4002};
    int n;
    acc(1'b1, sts_pkg::CMD_ACTION, 16'h0080, 1'b0, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, sts_pkg::CMD_LIMIT, lim[i], 1'b0, 16'h0000);
      ramp_ms = (i == 5) ? 7'h02 : 7'h01;
      on_cmd = 1'b1;
      wait_hi(status_tonmax_r, (exp_ms[i] + 2) * TICKS, n);
      in_win(n, exp_ms[i]);
      chk({12'h000, status_tonmax_r, status_other_r, status_vout_warn_r, smbalert_r}, 16'h000F);
      repeat (3 * TICKS) @(negedge clk_sys);
      chk({15'h0000, out_en_r}, 16'h0000);
      on_cmd = 1'b0;
      clr();
      chk({12'h000, status_tonmax_r, status_other_r, status_vout_warn_r, smbalert_r}, 16'h0000);
    end
    $display("t_buckets done");
  endtask

  task automatic t_ignore();
    int n;
    acc(1'b1, sts_pkg::CMD_ACTION, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, sts_pkg::CMD_TOFF, 16'h0003, 1'b0, 16'h0000);
    alert_mask = 1'b1;
    ramp_ms = 7'h01;
    on_cmd = 1'b1;
    wait_hi(status_tonmax_r, 3 * TICKS, n);
    repeat (2 * TICKS) @(negedge clk_sys);
    chk({11'h000, status_tonmax_r, status_other_r, status_vout_warn_r, smbalert_r, out_en_r}, 16'h001D);
    on_cmd = 1'b0;
    wait_hi(ramp_down_r, 6 * TICKS, n);
    in_win(n, 3);
    alert_mask = 1'b0;
    clr();
    $display("t_ignore done");
  endtask

  task automatic t_retry();
    int n;
    acc(1'b1, sts_pkg::CMD_ACTION, 16'h00BF, 1'b0, 16'h0000);
    on_cmd = 1'b1;
    wait_hi(status_tonmax_r, 3 * TICKS, n);
    @(negedge clk_sys);
    chk({14'h0000, out_en_r, soft_start_r}, 16'h0000);
    wait_hi(soft_start_r, 9 * TICKS, n);
    in_win(n + 1, 7);
    vout_above_uv = 1'b1;
    clr();
    repeat (3 * TICKS) @(negedge clk_sys);
    chk({14'h0000, status_tonmax_r, out_en_r}, 16'h0001);
    on_cmd = 1'b0;
    wait_hi(ramp_down_r, 6 * TICKS, n);
    in_win(n, 3);
    vout_above_uv = 1'b0;
    $display("t_retry done");
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_secondary();
    t_buckets();
    t_ignore();
    t_retry();
    final_report();
  end
endmodule // tb_sts_sequencer

`default_nettype wire
